// ==== pkg/sense_consts.vh ====
`ifndef SENSE_CONSTS_VH
`define SENSE_CONSTS_VH

// sense data geometry
`define SENSE_LEN        6'h20
`define SENSE_ADDL_LEN   8'h18
`define SENSE_IDX_W      5
`define SENSE_LAST_IDX   5'h1F

// byte positions
`define BYTE_RESP        5'h00
`define BYTE_KEY         5'h02
`define BYTE_INFO_MSB    5'h03
`define BYTE_INFO_B1     5'h04
`define BYTE_INFO_B2     5'h05
`define BYTE_INFO_LSB    5'h06
`define BYTE_ADDL_LEN    5'h07
`define BYTE_ASC         5'h0C
`define BYTE_ASCQ        5'h0D

// bit positions
`define BIT_VALID        7
`define BIT_ILI          5

// response codes
`define RESP_CURRENT     7'h70
`define RESP_DEFERRED    7'h71

// command opcodes
`define OP_LONG_READ     8'h3E
`define OP_LONG_WRITE    8'h3F

// sense keys
`define KEY_NONE         4'h0
`define KEY_RECOVERED    4'h1
`define KEY_NOT_READY    4'h2
`define KEY_MEDIUM       4'h3
`define KEY_HARDWARE     4'h4
`define KEY_ILLEGAL      4'h5
`define KEY_UNIT_ATTN    4'h6
`define KEY_PROTECT      4'h7
`define KEY_UNUSED_8     4'h8
`define KEY_UNUSED_A     4'hA
`define KEY_ABORTED      4'hB
`define KEY_UNUSED_C     4'hC
`define KEY_UNUSED_D     4'hD
`define KEY_MISCOMPARE   4'hE
`define KEY_COMPLETED    4'hF

// additional codes
`define ASC_NONE         8'h00
`define ASCQ_NONE        8'h00
`define ASC_SMART        8'h0B
`define ASCQ_TEMP        8'h01
`define ASCQ_SELFTEST    8'h03
`define ASCQ_PRESCAN     8'h04
`define ASCQ_MEDIASCAN   8'h05

// largest LBA reported as information in fixed format
`define INFO_MAX         64'h000000000FFFFFFF

`endif

// ==== core/sense_mem.v ====
`timescale 1ns/1ns
`include "sense_consts.vh"

module sense_mem (
  input  wire                      mclk,
  input  wire                      wr_en,
  input  wire [`SENSE_IDX_W-1:0]   wr_addr,
  input  wire [7:0]                wr_data,
  input  wire [`SENSE_IDX_W-1:0]   rd_addr,
  output reg  [7:0]                rd_data_q
);

  reg [7:0] mem [0:31];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

// ==== core/sense_encode.v ====
`timescale 1ns/1ns
`include "sense_consts.vh"

module sense_encode (
  input  wire [7:0]   opcode,
  input  wire [3:0]   key_in,
  input  wire         recovered_ok,
  input  wire [7:0]   asc_in,
  input  wire [7:0]   ascq_in,
  input  wire [3:0]   smart_evt,
  input  wire         len_mismatch,
  input  wire [31:0]  req_len,
  input  wire [31:0]  blk_len,
  input  wire         lba_valid,
  input  wire [63:0]  lba,
  input  wire [63:0]  cmd_lba,
  input  wire [31:0]  cmd_blocks,
  output reg          valid,
  output reg          ili,
  output reg  [3:0]   key,
  output reg  [31:0]  info,
  output reg  [7:0]   asc,
  output reg  [7:0]   ascq
);

  wire        is_long;
  wire [64:0] cmd_end;
  wire        in_range;
  wire        fits;

  assign is_long  = (opcode == `OP_LONG_READ) ||
                    (opcode == `OP_LONG_WRITE);
  assign cmd_end  = {1'b0, cmd_lba} + {33'h0, cmd_blocks};
  assign in_range = (lba >= cmd_lba) && ({1'b0, lba} < cmd_end);
  assign fits     = (lba <= `INFO_MAX);

  always @* begin
    ili   = is_long && len_mismatch;
    valid = 1'b0;
    info  = 32'h00000000;
    if (ili) begin
      valid = 1'b1;
      info  = req_len - blk_len;
    end else if (lba_valid && in_range && fits) begin
      valid = 1'b1;
      info  = lba[31:0];
    end
    key  = key_in;
    asc  = asc_in;
    ascq = ascq_in;
    case (key_in)
      `KEY_UNUSED_8, `KEY_UNUSED_A,
      `KEY_UNUSED_C, `KEY_UNUSED_D: key = `KEY_HARDWARE;
      `KEY_RECOVERED: begin
        if (!recovered_ok) begin
          key = `KEY_HARDWARE;
        end
      end
      default: key = key_in;
    endcase
    if (smart_evt != 4'h0) begin
      key = `KEY_NONE;
      asc = `ASC_SMART;
      if (smart_evt[0]) begin
        ascq = `ASCQ_TEMP;
      end else if (smart_evt[1]) begin
        ascq = `ASCQ_SELFTEST;
      end else if (smart_evt[2]) begin
        ascq = `ASCQ_PRESCAN;
      end else begin
        ascq = `ASCQ_MEDIASCAN;
      end
    end else if (key == `KEY_NONE && asc_in == `ASC_NONE) begin
      ascq = `ASCQ_NONE;
    end
  end

endmodule

// ==== core/sense_builder.v ====
`timescale 1ns/1ns
`include "sense_consts.vh"


module sense_builder (
  input  wire         mclk,
  input  wire         rst,
  input  wire         build,
  input  wire         deferred,
  input  wire [7:0]   opcode,
  input  wire [3:0]   key_in,
  input  wire         recovered_ok,
  input  wire         cdb_param_err,
  input  wire [7:0]   asc_in,
  input  wire [7:0]   ascq_in,
  input  wire [3:0]   smart_evt,
  input  wire         len_mismatch,
  input  wire [31:0]  req_len,
  input  wire [31:0]  blk_len,
  input  wire         lba_valid,
  input  wire [63:0]  lba,
  input  wire [63:0]  cmd_lba,
  input  wire [31:0]  cmd_blocks,
  input  wire         fetch,
  input  wire [7:0]   alloc_len,
  output reg          ready_q,
  output reg          medium_locked_q,
  output reg          out_valid_q,
  output reg  [7:0]   out_byte_q,
  output reg          out_last_q,
  output reg  [5:0]   out_count_q
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FILL = 3'b010;
  localparam [2:0] ST_SEND = 3'b100;

  reg  [2:0]   state_q;
  reg  [4:0]   fill_idx_q;
  reg  [4:0]   rd_idx_q;
  reg  [5:0]   send_left_q;
  reg          rd_pend_q;
  reg          rd_last_q;
  reg          resp_def_q;
  reg  [7:0]   op_q;
  reg  [3:0]   key_q;
  reg          rec_q;
  reg  [7:0]   asc_q;
  reg  [7:0]   ascq_q;
  reg  [3:0]   smart_q;
  reg          mis_q;
  reg  [31:0]  req_q;
  reg  [31:0]  blk_q;
  reg          lbav_q;
  reg  [63:0]  lba_q;
  reg  [63:0]  clba_q;
  reg  [31:0]  cblk_q;

  wire         e_valid;
  wire         e_ili;
  wire [3:0]   e_key;
  wire [31:0]  e_info;
  wire [7:0]   e_asc;
  wire [7:0]   e_ascq;
  wire [7:0]   rd_data;
  wire [7:0]   fill_byte;
  wire [5:0]   send_len;

  // decoded state and handshake takes
  wire         idle;
  wire         filling;
  wire         sending;
  wire         take_build;
  wire         take_fetch;
  wire         fill_done;
  wire         send_done;
  wire         medium_locked_d;

  function [7:0] byte_at;
    input [4:0]  idx;
    input        vld;
    input        dfr;
    input        il;
    input [3:0]  k;
    input [31:0] inf;
    input [7:0]  c;
    input [7:0]  q;
    begin
      case (idx)
        `BYTE_RESP:     byte_at = {vld, dfr ? `RESP_DEFERRED
                                            : `RESP_CURRENT};
        `BYTE_KEY:      byte_at = {2'b00, il, 1'b0, k};
        `BYTE_INFO_MSB: byte_at = inf[31:24];
        `BYTE_INFO_B1:  byte_at = inf[23:16];
        `BYTE_INFO_B2:  byte_at = inf[15:8];
        `BYTE_INFO_LSB: byte_at = inf[7:0];
        `BYTE_ADDL_LEN: byte_at = `SENSE_ADDL_LEN;
        `BYTE_ASC:      byte_at = c;
        `BYTE_ASCQ:     byte_at = q;
        default:        byte_at = 8'h00;
      endcase
    end
  endfunction

  function [5:0] min_len;
    input [7:0] a;
    begin
      if (a < {2'b00, `SENSE_LEN}) begin
        min_len = a[5:0];
      end else begin
        min_len = `SENSE_LEN;
      end
    end
  endfunction

  // field encoding from the captured command
  sense_encode u_enc (
    .opcode       (op_q),
    .key_in       (key_q),
    .recovered_ok (rec_q),
    .asc_in       (asc_q),
    .ascq_in      (ascq_q),
    .smart_evt    (smart_q),
    .len_mismatch (mis_q),
    .req_len      (req_q),
    .blk_len      (blk_q),
    .lba_valid    (lbav_q),
    .lba          (lba_q),
    .cmd_lba      (clba_q),
    .cmd_blocks   (cblk_q),
    .valid        (e_valid),
    .ili          (e_ili),
    .key          (e_key),
    .info         (e_info),
    .asc          (e_asc),
    .ascq         (e_ascq)
  );

  assign fill_byte = byte_at(fill_idx_q, e_valid, resp_def_q, e_ili,
                             e_key, e_info, e_asc, e_ascq);
  assign send_len  = min_len(alloc_len);

  // state decode; build wins over fetch
  assign idle       = (state_q == ST_IDLE);
  assign filling    = (state_q == ST_FILL);
  assign sending    = (state_q == ST_SEND);
  assign take_build = idle && build;
  assign take_fetch = idle && !build && fetch;
  assign fill_done  = filling && (fill_idx_q == `SENSE_LAST_IDX);
  assign send_done  = sending && (send_left_q == 6'h01);
  assign medium_locked_d = (key_in == `KEY_ILLEGAL) && cdb_param_err &&
                           (smart_evt == 4'h0);

  // sense byte store, read data registered
  sense_mem u_mem (
    .mclk      (mclk),
    .wr_en     (filling),
    .wr_addr   (fill_idx_q),
    .wr_data   (fill_byte),
    .rd_addr   (rd_idx_q),
    .rd_data_q (rd_data)
  );

  // command capture
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_def_q      <= 1'b0;
      op_q            <= 8'h00;
      key_q           <= 4'h0;
      rec_q           <= 1'b0;
      asc_q           <= 8'h00;
      ascq_q          <= 8'h00;
      smart_q         <= 4'h0;
      mis_q           <= 1'b0;
      req_q           <= 32'h00000000;
      blk_q           <= 32'h00000000;
      lbav_q          <= 1'b0;
      lba_q           <= 64'h0000000000000000;
      clba_q          <= 64'h0000000000000000;
      cblk_q          <= 32'h00000000;
    end else if (take_build) begin
      resp_def_q      <= deferred;
      op_q            <= opcode;
      key_q           <= key_in;
      rec_q           <= recovered_ok;
      asc_q           <= asc_in;
      ascq_q          <= ascq_in;
      smart_q         <= smart_evt;
      mis_q           <= len_mismatch;
      req_q           <= req_len;
      blk_q           <= blk_len;
      lbav_q          <= lba_valid;
      lba_q           <= lba;
      clba_q          <= cmd_lba;
      cblk_q          <= cmd_blocks;
    end
  end

  // lock flag of the last build
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      medium_locked_q <= 1'b0;
    end else if (take_build) begin
      medium_locked_q <= medium_locked_d;
    end
  end

  // fill and send sequencing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      fill_idx_q  <= 5'h00;
      rd_idx_q    <= 5'h00;
      send_left_q <= 6'h00;
      rd_pend_q   <= 1'b0;
      rd_last_q   <= 1'b0;
      ready_q     <= 1'b1;
    end else begin
      rd_pend_q   <= 1'b0;
      rd_last_q   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take_build) begin
            state_q    <= ST_FILL;
            fill_idx_q <= 5'h00;
            ready_q    <= 1'b0;
          end else if (take_fetch && send_len != 6'h00) begin
            state_q     <= ST_SEND;
            rd_idx_q    <= 5'h00;
            send_left_q <= send_len;
            ready_q     <= 1'b0;
          end
        end
        ST_FILL: begin
          fill_idx_q <= fill_idx_q + 5'h01;
          if (fill_done) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        ST_SEND: begin
          rd_pend_q   <= 1'b1;
          rd_idx_q    <= rd_idx_q + 5'h01;
          send_left_q <= send_left_q - 6'h01;
          if (send_done) begin
            rd_last_q <= 1'b1;
            state_q   <= ST_IDLE;
            ready_q   <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // output stage, one byte per cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_byte_q  <= 8'h00;
      out_last_q  <= 1'b0;
    end else begin
      out_valid_q <= rd_pend_q;
      out_last_q  <= rd_last_q;
      if (rd_pend_q) begin
        out_byte_q <= rd_data;
      end
    end
  end

  // byte count of the last fetch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_count_q <= 6'h00;
    end else if (take_fetch) begin
      out_count_q <= send_len;
    end
  end

endmodule

// ==== testbench/sense_host.sv ====
`timescale 1ns/1ns
module sense_host (
  input wire       mclk,
  input wire       rst,
  input wire       out_valid_q,
  input wire [7:0] out_byte_q,
  input wire       out_last_q
);
  reg     [7:0] got [0:1023];
  integer       cnt;
  // takes every byte offered, truncated count or not
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
    end else if (out_valid_q) begin
      got[cnt[9:0]] <= out_byte_q;
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== testbench/sense_builder_chk.sv ====
`timescale 1ns/1ns
module sense_builder_chk (
  input wire       mclk,
  input wire       rst,
  input wire       build,
  input wire       fetch,
  input wire [3:0] key_in,
  input wire       cdb_param_err,
  input wire [3:0] smart_evt,
  input wire [7:0] alloc_len,
  input wire       ready_q,
  input wire       medium_locked_q,
  input wire       out_valid_q,
  input wire [7:0] out_byte_q,
  input wire       out_last_q,
  input wire [5:0] out_count_q
);
  reg  [5:0] n_q;
  reg        v_q;
  wire       bld = build && ready_q;
  wire       fet = fetch && !build && ready_q;
  wire [5:0] lim = alloc_len > 8'h20 ? 6'h20 : alloc_len[5:0];
  wire       lk = key_in == 4'h5 && cdb_param_err && smart_evt == 4'h0;
  wire       ob = out_valid_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // byte index within the current fetch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      n_q <= 6'h00;
      v_q <= 1'b0;
    end else if (ob) begin
      n_q <= out_last_q ? 6'h00 : n_q + 6'h01;
      if (n_q == 6'h00) v_q <= out_byte_q[7];
    end
  end
  property p_fill; bld |=> !ready_q [*8] ##25 ready_q; endproperty
  property p_cnt; fet |=> out_count_q == $past(lim); endproperty
  property p_first; fet && lim != 6'h00 |-> ##3 ob; endproperty
  property p_none; fet && lim == 6'h00 |-> ##3 !ob; endproperty
  property p_lock; bld |=> medium_locked_q == $past(lk); endproperty
  property p_hold; !bld |=> $stable(medium_locked_q); endproperty
  property p_last; out_last_q |-> ob && n_q < 6'h20; endproperty
  property p_b0;
    ob && n_q == 6'h00 |-> out_byte_q[6:0] inside {7'h70, 7'h71};
  endproperty
  property p_key; ob && n_q == 6'h02 |->
    !(out_byte_q[3:0] inside {4'h8, 4'hA, 4'hC, 4'hD}); endproperty
  property p_ili; ob && n_q == 6'h02 && out_byte_q[5] |-> v_q; endproperty
  property p_info0;
    ob && !v_q && n_q >= 6'h03 && n_q <= 6'h06 |-> out_byte_q == 8'h00;
  endproperty
  property p_b7; ob && n_q == 6'h07 |-> out_byte_q == 8'h18; endproperty
  property p_zero; ob && (n_q == 6'h01 || (n_q >= 6'h08 && n_q <= 6'h0B)
    || n_q >= 6'h0E) |-> out_byte_q == 8'h00; endproperty
  a_fill: assert property (p_fill) else $error("fill length wrong");
  a_cnt: assert property (p_cnt) else $error("byte count wrong");
  a_first: assert property (p_first) else $error("no first byte");
  a_none: assert property (p_none) else $error("byte for zero");
  a_lock: assert property (p_lock) else $error("lock flag wrong");
  a_hold: assert property (p_hold) else $error("lock flag moved");
  a_last: assert property (p_last) else $error("last misplaced");
  a_b0: assert property (p_b0) else $error("response code bad");
  a_key: assert property (p_key) else $error("unused key sent");
  a_ili: assert property (p_ili) else $error("ili without valid");
  a_info0: assert property (p_info0) else $error("info not zero");
  a_b7: assert property (p_b7) else $error("length byte bad");
  a_zero: assert property (p_zero) else $error("zero byte bad");
  c_bld: cover property (bld);
  c_full: cover property (fet && lim == 6'h20);
  c_lock: cover property ($rose(medium_locked_q));
endmodule
bind sense_builder sense_builder_chk chk (.mclk(mclk), .rst(rst),
  .build(build), .fetch(fetch), .key_in(key_in),
  .cdb_param_err(cdb_param_err), .smart_evt(smart_evt),
  .alloc_len(alloc_len), .ready_q(ready_q),
  .medium_locked_q(medium_locked_q), .out_valid_q(out_valid_q),
  .out_byte_q(out_byte_q), .out_last_q(out_last_q),
  .out_count_q(out_count_q));

// ==== testbench/fixed_sense_data_builder_bench.sv ====
`timescale 1ns/1ns
module fixed_sense_data_builder_bench;
  reg          mclk, rst, build, deferred, recovered_ok, fetch;
  reg          cdb_param_err, len_mismatch, lba_valid;
  reg  [7:0]   opcode, asc_in, ascq_in, alloc_len;
  reg  [3:0]   key_in, smart_evt;
  reg  [31:0]  req_len, blk_len, cmd_blocks;
  reg  [63:0]  lba, cmd_lba;
  wire         ready_q, medium_locked_q, out_valid_q, out_last_q;
  wire [7:0]   out_byte_q;
  wire [5:0]   out_count_q;
  integer      miscompares, checked, i, j;
  sense_builder dut (.mclk(mclk), .rst(rst), .build(build),
    .deferred(deferred), .opcode(opcode), .key_in(key_in),
    .recovered_ok(recovered_ok), .cdb_param_err(cdb_param_err),
    .asc_in(asc_in), .ascq_in(ascq_in), .smart_evt(smart_evt),
    .len_mismatch(len_mismatch), .req_len(req_len), .blk_len(blk_len),
    .lba_valid(lba_valid), .lba(lba), .cmd_lba(cmd_lba),
    .cmd_blocks(cmd_blocks), .fetch(fetch), .alloc_len(alloc_len),
    .ready_q(ready_q), .medium_locked_q(medium_locked_q),
    .out_valid_q(out_valid_q), .out_byte_q(out_byte_q),
    .out_last_q(out_last_q), .out_count_q(out_count_q));
  sense_host h (.mclk(mclk), .rst(rst), .out_valid_q(out_valid_q),
    .out_byte_q(out_byte_q), .out_last_q(out_last_q));
  function [7:0] exp_byte(input integer n);
    reg [3:0]  k;
    reg [7:0]  c, q;
    reg        v, il;
    reg [31:0] inf;
    begin
      k = key_in;
      if (k == 4'h8 || k == 4'hA || k == 4'hC || k == 4'hD ||
          (k == 4'h1 && !recovered_ok)) k = 4'h4;
      c = asc_in;
      q = ascq_in;
      if (smart_evt != 4'h0) begin
        k = 4'h0;
        c = 8'h0B;
        q = smart_evt[0] ? 8'h01 : smart_evt[1] ? 8'h03 :
            smart_evt[2] ? 8'h04 : 8'h05;
      end
      if (k == 4'h0 && c == 8'h00) q = 8'h00;
      il = len_mismatch && (opcode == 8'h3E || opcode == 8'h3F);
      v = il || (lba_valid && lba <= 64'h0FFFFFFF && lba >= cmd_lba &&
          lba < cmd_lba + cmd_blocks);
      inf = il ? req_len - blk_len : v ? lba[31:0] : 32'h0;
      case (n)
        0: exp_byte = {v, deferred ? 7'h71 : 7'h70};
        2: exp_byte = {2'b00, il, 1'b0, k};
        3: exp_byte = inf[31:24];
        4: exp_byte = inf[23:16];
        5: exp_byte = inf[15:8];
        6: exp_byte = inf[7:0];
        7: exp_byte = 8'h18;
        12: exp_byte = c;
        13: exp_byte = q;
        default: exp_byte = 8'h00;
      endcase
    end
  endfunction
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task do_build(input integer s);
    reg [63:0] t;
    reg [31:0] r;
    integer    b;
    begin
      r = $urandom;
      t = s == 21 ? 64'h0FFFFFFF : s == 22 ? 64'h10000000 :
          {32'h0, $urandom & 32'h0FFFFFFF};
      b = h.cnt;
      @(posedge mclk);
      build <= 1'b1;
      key_in <= s[3:0];
      deferred <= r[0];
      recovered_ok <= r[1];
      cdb_param_err <= r[2];
      len_mismatch <= r[3];
      asc_in <= s[2] ? 8'h00 : r[15:8];
      ascq_in <= r[23:16];
      opcode <= s[1] ? {7'h1F, s[0]} : r[31:24];
      smart_evt <= (s > 15 && s < 20) ? 4'h1 << (s - 16) :
                   s == 20 ? 4'h6 : 4'h0;
      cmd_blocks <= {30'h0, r[5:4]};
      cmd_lba <= t - {62'h0, r[7:6]};
      lba <= t;
      lba_valid <= s != 23;
      req_len <= $urandom;
      blk_len <= $urandom;
      @(posedge mclk);
      build <= 1'b0;
      @(posedge mclk);
      fetch <= 1'b1;
      @(posedge mclk);
      fetch <= 1'b0;
      j = 0;
      while (!ready_q && j < 40) begin
        @(negedge mclk);
        j = j + 1;
      end
      cmp({7'h0, ready_q}, 8'h01);
      repeat (4) @(posedge mclk);
      j = h.cnt - b;
      cmp(j[7:0], 8'h00);
      cmp({7'h0, medium_locked_q}, {7'h0, key_in == 4'h5 &&
          cdb_param_err && smart_evt == 4'h0});
    end
  endtask
  task do_fetch(input [7:0] a);
    integer b, n;
    begin
      b = h.cnt;
      n = a > 8'h20 ? 32 : a;
      @(posedge mclk);
      fetch <= 1'b1;
      alloc_len <= a;
      @(posedge mclk);
      fetch <= 1'b0;
      repeat (n + 5) @(posedge mclk);
      cmp({2'b00, out_count_q}, n[7:0]);
      j = h.cnt - b;
      cmp(j[7:0], n[7:0]);
      for (j = 0; j < n; j = j + 1)
        cmp(h.got[b + j], exp_byte(j));
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial begin
    miscompares = 0;
    checked = 0;
    {rst, build, deferred, recovered_ok, fetch, cdb_param_err} = 6'h20;
    {len_mismatch, lba_valid, opcode, asc_in, ascq_in} = 26'h0;
    {alloc_len, key_in, smart_evt, req_len, blk_len} = 80'h0;
    {cmd_blocks, lba, cmd_lba} = 160'h0;
    i = $urandom(32'h225251C5);
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    do_fetch(8'h00);
    for (i = 0; i < 28; i = i + 1) begin
      do_build(i);
      do_fetch(i == 7 ? 8'h01 : i == 9 ? 8'hFF : i == 11 ? 8'h1F :
               8'h20);
    end
    report_and_stop;
  end
endmodule
